/* include/phymo_map.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz clock, 10 ns period
// Notes:   all four symbol counts in cycles are top-level parameters
`ifndef PHYMO_MAP_SVH
`define PHYMO_MAP_SVH

`define PHYMO_ADDR_W          6
`define PHYMO_CTRL_OFFSET     6'h0C
`define PHYMO_CTRL_RESET      8'h24
`define PHYMO_BIT_SCRAMBLE    5
`define PHYMO_BIT_ALTSHAPE    4
`define PHYMO_BIT_MODULATION  3
`define PHYMO_BIT_CHIPRATE    2
`define PHYMO_RATE_HI         1
`define PHYMO_RATE_LO         0
`define PHYMO_RSSI_W          8

`define PHYMO_CLK_NS          10
`define PHYMO_SYM_US_BPSK20   50
`define PHYMO_SYM_US_BPSK40   25
`define PHYMO_SYM_US_OQ400    40
`define PHYMO_SYM_US_OQ1000   16
`define PHYMO_CYC(us)         (((us) * 1000) / `PHYMO_CLK_NS)

`define PHYMO_ACK_SYM_STD     4'd12
`define PHYMO_ACK_SYM_SHORT_L 4'd2
`define PHYMO_ACK_SYM_SHORT_H 4'd3
`define PHYMO_ED_SYM_STD      4'd8
`define PHYMO_ED_SYM_HDR      4'd2

`endif

/* include/phymo_pkg.sv */
// Purpose: types shared by the phy mode block
// Assumes: constants come from phymo_map.svh
// Notes:   rates are in kb/s
package phymo_pkg;

  typedef enum logic [2:0] {
    SHP_RC10,
    SHP_SIN_RC02,
    SHP_RC02,
    SHP_SIN,
    SHP_RC08
  } phymo_shape_e;

  typedef struct packed {
    logic         oqpsk;
    logic         chipRateHigh;
    logic         highRate;
    logic         rateReserved;
    logic         scrambleActive;
    logic         altChipSeq;
    logic         carrierSenseOk;
    logic         lqiUseful;
    phymo_shape_e txShaping;
    logic [9:0]   headerRateKbps;
    logic [9:0]   payloadRateKbps;
  } phymo_mode_s;

endpackage : phymo_pkg

/* rtl/phymo_core.sv */
// Purpose: phy mode control register, mode decode, ack and ED timing
// Assumes: register port driven by the host interface on clk
// Notes:   host keeps the radio idle while changing mode bits
`timescale 1ns/100ps
`include "phymo_map.svh"

module phymo_core #(
  parameter int SYM_CYC_BPSK20 = `PHYMO_CYC(`PHYMO_SYM_US_BPSK20),
  parameter int SYM_CYC_BPSK40 = `PHYMO_CYC(`PHYMO_SYM_US_BPSK40),
  parameter int SYM_CYC_OQ400  = `PHYMO_CYC(`PHYMO_SYM_US_OQ400),
  parameter int SYM_CYC_OQ1000 = `PHYMO_CYC(`PHYMO_SYM_US_OQ1000)
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic [`PHYMO_ADDR_W-1:0]   regAddr,
  input  wire logic                       regWrite,
  input  wire logic [7:0]                 regWrData,
  output logic      [7:0]                 regRdData,
  input  wire logic                       shortAckTime,
  input  wire logic [`PHYMO_RSSI_W-1:0]   syncThresholdLevel,
  input  wire logic [`PHYMO_RSSI_W-1:0]   rssiLevel,
  input  wire logic                       rxActive,
  input  wire logic                       framePsdu,
  input  wire logic                       ackStart,
  input  wire logic                       edStartAuto,
  input  wire logic                       edStartManual,
  output phymo_pkg::phymo_mode_s          modeStatus,
  output logic      [9:0]                 lineRateKbps,
  output logic                            syncAllowed,
  output logic                            ackDue,
  output logic                            edBusy,
  output logic                            edDone
);
  import phymo_pkg::*;

  logic [7:0]   ctrl_reg;
  logic [7:0]   ctrl_next;
  phymo_mode_s  mode_next;
  logic [15:0]  symCycles;
  logic [3:0]   ackSymbols;
  logic [15:0]  ackCyc_reg;
  logic [3:0]   ackSym_reg;
  logic         ackRun_reg;
  logic [15:0]  edCyc_reg;
  logic [3:0]   edSym_reg;
  logic [3:0]   edLen_reg;
  logic         scrEn;
  logic         altSel;
  logic         modSel;
  logic         chipSel;
  logic [1:0]   rateSel;

  assign scrEn   = ctrl_reg[`PHYMO_BIT_SCRAMBLE];
  assign altSel  = ctrl_reg[`PHYMO_BIT_ALTSHAPE];
  assign modSel  = ctrl_reg[`PHYMO_BIT_MODULATION];
  assign chipSel = ctrl_reg[`PHYMO_BIT_CHIPRATE];
  assign rateSel = ctrl_reg[`PHYMO_RATE_HI:`PHYMO_RATE_LO];

  // register write; reserved bits 7:6 are not stored
  always_comb begin
    ctrl_next = ctrl_reg;
    if (regWrite && regAddr == `PHYMO_CTRL_OFFSET) begin
      ctrl_next = {2'h0, regWrData[5:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= `PHYMO_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regAddr == `PHYMO_CTRL_OFFSET) begin
      regRdData <= ctrl_reg;
    end else begin
      regRdData <= 8'h00;
    end
  end

  // mode decode from the control register
  always_comb begin
    mode_next              = '0;
    mode_next.oqpsk        = modSel;
    mode_next.chipRateHigh = chipSel;
    mode_next.txShaping    = SHP_RC10;
    if (!modSel) begin
      mode_next.headerRateKbps  = chipSel ? 10'd40 : 10'd20;
      mode_next.payloadRateKbps = mode_next.headerRateKbps;
      mode_next.altChipSeq      = chipSel & altSel;
    end else begin
      mode_next.headerRateKbps = chipSel ? 10'd250 : 10'd100;
      case (rateSel)
        2'd0: mode_next.payloadRateKbps = chipSel ? 10'd250 : 10'd100;
        2'd1: mode_next.payloadRateKbps = chipSel ? 10'd500 : 10'd200;
        2'd2: mode_next.payloadRateKbps = chipSel ? 10'd1000 : 10'd400;
        default: begin
          mode_next.payloadRateKbps = chipSel ? 10'd500 : 10'd100;
          mode_next.rateReserved    = !chipSel;
        end
      endcase
      mode_next.highRate = (rateSel != 2'd0) && !mode_next.rateReserved;
      mode_next.scrambleActive = scrEn && (rateSel == 2'd2);
      // transmit shaping only; receive never looks at the alternate bit
      if (chipSel) begin
        mode_next.txShaping = altSel ? SHP_RC08 : SHP_SIN;
      end else begin
        mode_next.txShaping = altSel ? SHP_RC02 : SHP_SIN_RC02;
      end
    end
    mode_next.carrierSenseOk = !mode_next.highRate;
    mode_next.lqiUseful      = !mode_next.highRate;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      modeStatus <= '0;
    end else begin
      modeStatus <= mode_next;
    end
  end

  // raised rate applies only while the payload is on air
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lineRateKbps <= 10'd0;
    end else if (framePsdu) begin
      lineRateKbps <= mode_next.payloadRateKbps;
    end else begin
      lineRateKbps <= mode_next.headerRateKbps;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syncAllowed <= 1'b0;
    end else begin
      syncAllowed <= (syncThresholdLevel == '0) ||
                     (rssiLevel >= syncThresholdLevel);
    end
  end

  // symbol period of the current base mode
  always_comb begin
    if (!modSel) begin
      symCycles = chipSel ? 16'(SYM_CYC_BPSK40) : 16'(SYM_CYC_BPSK20);
    end else begin
      symCycles = chipSel ? 16'(SYM_CYC_OQ1000) : 16'(SYM_CYC_OQ400);
    end
  end

  always_comb begin
    ackSymbols = `PHYMO_ACK_SYM_STD;
    if (shortAckTime && mode_next.highRate) begin
      ackSymbols = chipSel ? `PHYMO_ACK_SYM_SHORT_H
                           : `PHYMO_ACK_SYM_SHORT_L;
    end
  end

  // ack timer: ackDue pulses after ackSymbols symbol periods
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ackRun_reg <= 1'b0;
      ackCyc_reg <= 16'h0000;
      ackSym_reg <= 4'h0;
      ackDue     <= 1'b0;
    end else begin
      ackDue <= 1'b0;
      if (ackStart) begin
        ackRun_reg <= 1'b1;
        ackCyc_reg <= 16'h0000;
        ackSym_reg <= 4'h0;
      end else if (ackRun_reg) begin
        if (ackCyc_reg == symCycles - 16'h0001) begin
          ackCyc_reg <= 16'h0000;
          if (ackSym_reg == ackSymbols - 4'h1) begin
            ackRun_reg <= 1'b0;
            ackDue     <= 1'b1;
          end else begin
            ackSym_reg <= ackSym_reg + 4'h1;
          end
        end else begin
          ackCyc_reg <= ackCyc_reg + 16'h0001;
        end
      end
    end
  end

  // energy detection timer; length is latched at start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      edBusy    <= 1'b0;
      edDone    <= 1'b0;
      edCyc_reg <= 16'h0000;
      edSym_reg <= 4'h0;
      edLen_reg <= `PHYMO_ED_SYM_STD;
    end else begin
      edDone <= 1'b0;
      if (!edBusy && (edStartManual || edStartAuto)) begin
        edBusy    <= 1'b1;
        edCyc_reg <= 16'h0000;
        edSym_reg <= 4'h0;
        if (!edStartManual && mode_next.highRate) begin
          edLen_reg <= `PHYMO_ED_SYM_HDR;
        end else begin
          edLen_reg <= `PHYMO_ED_SYM_STD;
        end
      end else if (edBusy) begin
        if (edCyc_reg == symCycles - 16'h0001) begin
          edCyc_reg <= 16'h0000;
          if (edSym_reg == edLen_reg - 4'h1) begin
            edBusy <= 1'b0;
            edDone <= 1'b1;
          end else begin
            edSym_reg <= edSym_reg + 4'h1;
          end
        end else begin
          edCyc_reg <= edCyc_reg + 16'h0001;
        end
      end
    end
  end

  // rxActive is only consumed here: shaping output carries no rx role
  chk_rx_shape_hold: assert property (@(posedge clk) disable iff (!reset_n)
    rxActive && $stable(ctrl_reg) |=> $stable(modeStatus.txShaping))
    else $error("shaping changed without a register change");

  chk_line_rate: assert property (@(posedge clk) disable iff (!reset_n)
    !framePsdu ##1 $stable(ctrl_reg)
      |-> lineRateKbps == modeStatus.headerRateKbps)
    else $error("header not sent at basic rate");

  chk_scramble_rate: assert property (@(posedge clk) disable iff (!reset_n)
    modeStatus.scrambleActive |-> modeStatus.oqpsk &&
      (modeStatus.payloadRateKbps == 10'd400 ||
       modeStatus.payloadRateKbps == 10'd1000))
    else $error("scrambling at wrong rate");

  chk_scramble_bit: assert property (@(posedge clk) disable iff (!reset_n)
    modSel && rateSel == 2'd2 && scrEn |=> modeStatus.scrambleActive
      || $changed(ctrl_reg))
    else $error("scrambler not enabled");

  chk_cs_high_rate: assert property (@(posedge clk) disable iff (!reset_n)
    modeStatus.highRate |-> !modeStatus.carrierSenseOk)
    else $error("carrier sense offered in high rate mode");

  chk_sync_thresh: assert property (@(posedge clk) disable iff (!reset_n)
    syncThresholdLevel != '0 && rssiLevel < syncThresholdLevel
      |=> !syncAllowed)
    else $error("sync allowed below threshold");

  // shaping is compared against the alternate bit of the decoded cycle
  chk_shape_1000: assert property (@(posedge clk) disable iff (!reset_n)
    modSel && chipSel |=>
      modeStatus.txShaping == ($past(altSel) ? SHP_RC08 : SHP_SIN))
    else $error("wrong 1000 kchip shaping");

  chk_shape_400: assert property (@(posedge clk) disable iff (!reset_n)
    modSel && !chipSel |=> modeStatus.txShaping ==
      ($past(altSel) ? SHP_RC02 : SHP_SIN_RC02))
    else $error("wrong 400 kchip shaping");

  chk_ed_manual: assert property (@(posedge clk) disable iff (!reset_n)
    !edBusy && edStartManual |=> edLen_reg == `PHYMO_ED_SYM_STD)
    else $error("manual ED not eight symbols");

  chk_ed_auto_hdr: assert property (@(posedge clk) disable iff (!reset_n)
    !edBusy && edStartAuto && !edStartManual && mode_next.highRate
      |=> edLen_reg == `PHYMO_ED_SYM_HDR)
    else $error("automated ED not two symbols");

  chk_ack_short: assert property (@(posedge clk) disable iff (!reset_n)
    shortAckTime && mode_next.highRate |->
      ackSymbols == (chipSel ? 4'd3 : 4'd2))
    else $error("short ack length wrong");

  chk_ack_std: assert property (@(posedge clk) disable iff (!reset_n)
    !shortAckTime |-> ackSymbols == 4'd12)
    else $error("standard ack length wrong");

endmodule : phymo_core

/* testbench/phymo_core_test.sv */
// Purpose: self-checking bench for the phy mode block
// Assumes: symbol periods shortened through parameters
// Notes:   peer model drives the air-side inputs
`timescale 1ns/100ps
`include "phymo_map.svh"
module phymo_core_test;
  import phymo_pkg::*;
  localparam int P20 = 10, P40 = 8, P4 = 6, P10 = 4;
  logic        clk = 0, reset_n = 0, regWrite = 0, shortAckTime = 0;
  logic        ackStart = 0, edStartAuto = 0, edStartManual = 0;
  logic        send = 0, inPsdu = 0, rxActive, framePsdu;
  logic [5:0]  regAddr = `PHYMO_CTRL_OFFSET;
  logic [7:0]  regWrData = 0, syncThresholdLevel = 0, power = 0;
  logic [7:0]  rssiLevel, regRdData;
  logic [9:0]  lineRateKbps;
  logic        syncAllowed, ackDue, edBusy, edDone;
  phymo_mode_s modeStatus, m;
  int          miscompares = 0, checked = 0, n, thr;
  logic [7:0]  d;
  logic [5:0]  tbl [6] = '{6'h00, 6'h04, 6'h08, 6'h0A, 6'h0E, 6'h0D};

  phymo_core #(.SYM_CYC_BPSK20(P20), .SYM_CYC_BPSK40(P40),
    .SYM_CYC_OQ400(P4), .SYM_CYC_OQ1000(P10)) i_dut (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrite(regWrite),
    .regWrData(regWrData), .regRdData(regRdData),
    .shortAckTime(shortAckTime), .syncThresholdLevel(syncThresholdLevel),
    .rssiLevel(rssiLevel), .rxActive(rxActive), .framePsdu(framePsdu),
    .ackStart(ackStart), .edStartAuto(edStartAuto),
    .edStartManual(edStartManual), .modeStatus(modeStatus),
    .lineRateKbps(lineRateKbps), .syncAllowed(syncAllowed),
    .ackDue(ackDue), .edBusy(edBusy), .edDone(edDone));
  phymo_peer_model i_peer (.clk(clk), .send(send), .inPsdu(inPsdu),
    .power(power), .rxActive(rxActive), .framePsdu(framePsdu),
    .rssiLevel(rssiLevel));

  always #5 clk = ~clk;

  function automatic phymo_mode_s expMode(logic [5:0] c);
    phymo_mode_s e;
    e = '0;
    e.oqpsk = c[3];
    e.chipRateHigh = c[2];
    e.rateReserved = c[3] & !c[2] & (c[1:0] == 2'h3);
    e.highRate = c[3] & (c[1:0] != 2'h0) & !e.rateReserved;
    e.scrambleActive = e.highRate & (c[1:0] == 2'h2) & c[5];
    e.altChipSeq = !c[3] & c[2] & c[4];
    e.carrierSenseOk = !e.highRate;
    e.lqiUseful = !e.highRate;
    e.txShaping = !c[3] ? SHP_RC10 : c[2] ? (c[4] ? SHP_RC08 : SHP_SIN)
                : (c[4] ? SHP_RC02 : SHP_SIN_RC02);
    e.headerRateKbps = c[3] ? (c[2] ? 10'h0FA : 10'h064)
                     : (c[2] ? 10'h028 : 10'h014);
    e.payloadRateKbps = e.headerRateKbps;
    // rate 2 is the four-fold code; rate 1 and, at the high chip rate, rate 3 are two-fold
    if (e.highRate)
      e.payloadRateKbps = e.headerRateKbps << ((c[1:0] == 2'h2) ? 2 : 1);
    return e;
  endfunction : expMode

  function automatic int symCyc(logic [5:0] c);
    return !c[3] ? (c[2] ? P40 : P20) : (c[2] ? P10 : P4);
  endfunction : symCyc

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= v;
    regWrite  <= 1;
    @(posedge clk);
    regWrite  <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr

  // kind 0 ack timer, 1 automated ED, 2 manual ED; n edges to done pulse
  task automatic measure(input int kind, output int cnt);
    cnt = 0;
    @(posedge clk);
    ackStart      <= (kind == 0);
    edStartAuto   <= (kind == 1);
    edStartManual <= (kind == 2);
    @(posedge clk);
    {ackStart, edStartAuto, edStartManual} <= 3'h0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
      if (kind != 0 && cnt == 1) chk("edBusy", 1, edBusy);
    end while (((kind == 0 ? ackDue : edDone) !== 1'b1) && cnt < 400);
    if (kind != 0) chk("edBusyEnd", 0, edBusy);
  endtask : measure

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end

  initial begin
    void'($urandom(42));
    repeat (20) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    #1;
    chk("ctrlReset", 8'h24, regRdData);
    chk("modeReset", expMode(6'h24), modeStatus);
    wr(6'h0D, 8'h3F);
    chk("unmapped", 8'h00, regRdData);
    chk("unmappedMode", expMode(6'h24), modeStatus);
    for (int i = 0; i < 96; i++) begin
      d = (i < 64) ? {2'($urandom_range(3, 0)), i[5:0]} : 8'($urandom);
      wr(`PHYMO_CTRL_OFFSET, d);
      chk("ctrl", {2'h0, d[5:0]}, regRdData);
      m = expMode(d[5:0]);
      chk("mode", m, modeStatus);
      chk("hdrRate", m.headerRateKbps, lineRateKbps);
      send   <= 1;
      inPsdu <= 1;
      repeat (3) @(posedge clk);
      #1;
      chk("psduRate", m.payloadRateKbps, lineRateKbps);
      send   <= 0;
      inPsdu <= 0;
      repeat (2) @(posedge clk);
    end
    foreach (tbl[k]) begin
      wr(`PHYMO_CTRL_OFFSET, {2'h0, tbl[k]});
      m = expMode(tbl[k]);
      for (int sa = 0; sa < 2; sa++) begin
        shortAckTime <= sa[0];
        measure(0, n);
        thr = (sa == 1 && m.highRate) ? (tbl[k][2] ? 3 : 2) : 12;
        chk("ackCycles", thr * symCyc(tbl[k]), n);
      end
      measure(1, n);
      chk("edAuto", (m.highRate ? 2 : 8) * symCyc(tbl[k]), n);
      measure(2, n);
      chk("edManual", 8 * symCyc(tbl[k]), n);
    end
    wr(`PHYMO_CTRL_OFFSET, 8'h1E);
    for (int j = 0; j < 24; j++) begin
      thr = (j == 0) ? 0 : $urandom_range(255, 1);
      d = (j == 1) ? thr[7:0] : (j == 2) ? thr[7:0] - 8'h01 : 8'($urandom);
      syncThresholdLevel <= thr[7:0];
      power <= d;
      send  <= 1;
      repeat (3) @(posedge clk);
      #1;
      chk("sync", (thr == 0) || (d >= thr), syncAllowed);
      chk("rxShape", expMode(6'h1E), modeStatus);
      send <= 0;
      @(posedge clk);
      #1;
    end
    end_of_test();
  end
endmodule : phymo_core_test

/* testbench/phymo_peer_model.sv */
// Purpose: peer radio as seen from the receive side of the block
// Assumes: one frame at a time, started and ended by the bench
// Notes:   rssi drops to the noise floor between frames
`timescale 1ns/100ps
module phymo_peer_model (
  input  wire logic       clk,
  input  wire logic       send,
  input  wire logic       inPsdu,
  input  wire logic [7:0] power,
  output logic            rxActive,
  output logic            framePsdu,
  output logic      [7:0] rssiLevel
);
  always_ff @(posedge clk) begin
    rxActive  <= send;
    // payload flag follows inPsdu whenever send is high; nothing here forces a header phase first
    framePsdu <= send & inPsdu;
    rssiLevel <= send ? power : 8'h00;
  end
endmodule : phymo_peer_model
